// [core/nbu_uart.sv]
// Nine-bit UART core with Wishbone register slave and address match
// Contract
// - 9-bit frames: start 0, eight data LSB first, ninth bit, stop 1.
// - Transmit ninth bit from tx_ninth_bit; received ninth bit into rx_ninth_bit.
// - Mode 2 bit rate is clock/64, or clock/32 with baud_double.
// - Data write requests send; start waits for next divide-by-16 rollover.
// - Send start then data; done flag set at eleventh rollover.
// - Falling edge at 16x resets counter and presets shift register to ones.
// - Each bit sampled at states 7, 8, 9 with majority vote.
// - Non-zero voted start bit abandons frame, edge search resumes.
// - Load only if rx_done clear and (multiproc off or ninth one).
// - Modes 2,3: stop bit value never affects buffer, ninth bit or done flag.
// - Mode 3 rate is 2^baud_double/32 of timer1 or baud timer overflow.
// - Timer overflow is clock/(256-reload), further /12 unless sped up.
// - Receive starts on edge only with rx_enable; mode 0 on enable (code never starts receive in mode 0).
// - Missing stop sets framing error; top bit shows it when selected.
// - Framing error stays until software clears it.
// - Multiproc ignored in mode 0; mode 1 needs valid stop.
// - Modes 2,3 multiproc: ninth one and address match needed.
// - Mode 1 multiproc: valid stop and address match needed.
// - Given address compares only bits whose mask bit is one.
// - Broadcast is addr OR mask; zero bits are don't care.
// - Address and mask reset to zero, so every address matches.
// - Two mode bits select mode; both zero is shift-register mode (code has no shift-register mode, it only blocks receive there).
// - Mode 1 frame is ten bits; stop bit goes to rx_ninth_bit.
`timescale 1ns/1ns
module nbu_uart
   import nbu_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [7:0] wbAdr,
   input wire logic [31:0] wbDatIn,
   input wire logic [3:0] wbSel,
   output logic [31:0] wbDatOut,
   output logic wbAck,
   input wire logic rxPin,
   output logic txPin,
   output logic serialIrq
);
   import nbu_pkg::*;
   // ****************************************
   // Registers and state
   // ****************************************
   logic [7:0] ctl;
   logic [20:0] baud;
   logic [7:0] rxBuf;
   logic [7:0] slaveAddr;
   logic [7:0] slaveAddrMask;
   logic frameErr;
   logic modeTop;
   logic [2:0] rxSync;
   logic rxLevel;
   logic [1:0] m2Div;
   logic [3:0] preDiv;
   logic [8:0] timerCnt;
   logic [3:0] txPhase;
   logic [3:0] rxPhase;
   logic [10:0] txShift;
   logic [3:0] txBits;
   logic txReq;
   logic txBusy;
   nbu_rx_e rxState;
   logic [8:0] rxShift;
   logic [3:0] rxBits;
   logic [1:0] voteCnt;
   logic stopSeen;
   // ****************************************
   // Bus decode
   // ****************************************
   wire busHit = wbCyc & wbStb & ~wbAck;
   wire busWr = busHit & wbWe & wbSel[0];
   wire wrCtl = busWr && wbAdr == OFS_CONTROL;
   wire wrData = busWr && wbAdr == OFS_DATA;
   wire wrAddr = busWr && wbAdr == OFS_ADDR;
   wire wrMask = busWr && wbAdr == OFS_MASK;
   wire wrBaud = busWr && wbAdr == OFS_BAUD;
   wire feSel = baud[BD_FESEL];
   wire [1:0] mode = {modeTop, ctl[CTL_MODE1]};
   wire topBit = feSel ? frameErr : modeTop;
   wire [31:0] rdMux = (wbAdr == OFS_CONTROL) ? {24'h0, topBit, ctl[6:0]} :
      (wbAdr == OFS_DATA) ? {24'h0, rxBuf} :
      (wbAdr == OFS_ADDR) ? {24'h0, slaveAddr} :
      (wbAdr == OFS_MASK) ? {24'h0, slaveAddrMask} :
      (wbAdr == OFS_BAUD) ? {11'h0, baud} : 32'h0;
   // ****************************************
   // Baud tick generation
   // ****************************************
   wire fastSrc = baud[BD_SRCSEL] ? baud[BD_BRTFAST] : baud[BD_T1FAST];
   wire [7:0] reload = baud[BD_SRCSEL] ? baud[BD_BRT +: 8] : baud[BD_RELOAD +: 8];
   wire preTick = fastSrc | (preDiv == SLOW_DIV);
   wire tmrOvf = preTick && timerCnt == TIMER_TOP - 9'h1;
   wire m2Tick = m2Div == (baud[BD_DOUBLE] ? M2_DIV_FAST : M2_DIV_SLOW);
   // Overflow gives 16x tick directly at /16 with baud_double, /32 needs halving
   logic ovfHalf;
   wire m3Tick = tmrOvf & (baud[BD_DOUBLE] | ovfHalf);
   wire tick = (mode == 2'b10) ? m2Tick : m3Tick;
   // Divider processes
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         m2Div <= 2'h0;
         preDiv <= 4'h0;
         timerCnt <= 9'h0;
         ovfHalf <= 1'b0;
      end else if (clkEn) begin
         m2Div <= m2Tick ? 2'h0 : m2Div + 2'h1;
         preDiv <= preTick ? 4'h0 : preDiv + 4'h1;
         if (tmrOvf) begin
            timerCnt <= {1'b0, reload};
            ovfHalf <= ~ovfHalf;
         end else if (preTick) begin
            timerCnt <= (timerCnt < {1'b0, reload}) ? {1'b0, reload} : timerCnt + 9'h1;
         end
      end
   end
   // ****************************************
   // Transmitter
   // ****************************************
   wire txRoll = tick && txPhase == 4'hf;
   wire nine = mode[1];
   // Start roll is the first rollover, so the frame ends when the stop bit begins
   wire txFinish = txBusy && txRoll && txBits == (nine ? FRAME9_BITS : FRAME8_BITS) - 4'h2;
   // Transmit sequencing
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txPhase <= 4'h0;
         txShift <= 11'h7ff;
         txBits <= 4'h0;
         txReq <= 1'b0;
         txBusy <= 1'b0;
         txPin <= 1'b1;
      end else if (clkEn) begin
         if (tick) begin
            txPhase <= txPhase + 4'h1;
         end
         if (wrData) begin
            txReq <= 1'b1;
            txShift <= {1'b1, nine ? ctl[CTL_TXNINTH] : 1'b1, wbDatIn[7:0], 1'b0};
         end else if (txRoll && txReq && !txBusy) begin
            txReq <= 1'b0;
            txBusy <= 1'b1;
            txBits <= 4'h0;
            txPin <= 1'b0;
         end else if (txRoll && txBusy) begin
            txShift <= {1'b1, txShift[10:1]};
            txPin <= txShift[1];
            txBits <= txBits + 4'h1;
            if (txFinish) begin
               txBusy <= 1'b0;
               txPin <= 1'b1;
            end
         end
      end
   end
   // ****************************************
   // Receiver
   // ****************************************
   wire sampleNow = tick && (rxPhase == SAMPLE_A || rxPhase == SAMPLE_B
      || rxPhase == SAMPLE_C);
   wire rxRoll = tick && rxPhase == 4'hf;
   wire rxLast = rxRoll && rxBits == (nine ? FRAME9_BITS : FRAME8_BITS) - 4'h1;
   wire stopOk = stopSeen;
   wire [7:0] rxByte = nine ? rxShift[7:0] : rxShift[8:1];
   wire ninthIn = nine ? rxShift[8] : stopOk;
   wire givenHit = ((rxByte ^ slaveAddr) & slaveAddrMask) == 8'h00;
   wire [7:0] bcast = slaveAddr | slaveAddrMask;
   wire bcastHit = ((~rxByte) & bcast) == 8'h00;
   wire addrHit = givenHit | bcastHit;
   wire mpOk = !ctl[CTL_MPEN] || (nine ? (rxShift[8] & addrHit) : (stopOk & addrHit));
   wire rxAccept = !ctl[CTL_RXDONE] && mpOk;
   // Pin synchroniser, stages 2 and 3 agree before a level change counts
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rxSync <= 3'h7;
         rxLevel <= 1'b1;
      end else if (clkEn) begin
         rxSync <= {rxSync[1:0], rxPin};
         if (rxSync[2] == rxSync[1]) begin
            rxLevel <= rxSync[2];
         end
      end
   end
   // Receive sequencing
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rxState <= RX_IDLE;
         rxPhase <= 4'h0;
         rxShift <= 9'h1ff;
         rxBits <= 4'h0;
         voteCnt <= 2'h0;
         stopSeen <= 1'b0;
      end else if (clkEn) begin
         unique case (rxState)
            RX_IDLE: begin
               if (tick) begin
                  rxPhase <= rxPhase + 4'h1;
               end
               if (tick && !rxLevel && ctl[CTL_RXEN] && mode != 2'b00) begin
                  rxState <= RX_BITS;
                  rxPhase <= 4'h0;
                  rxShift <= 9'h1ff;
                  rxBits <= 4'h0;
                  voteCnt <= 2'h0;
               end
            end
            RX_BITS: begin
               if (tick) begin
                  rxPhase <= rxPhase + 4'h1;
               end
               if (sampleNow && rxLevel && voteCnt != 2'h3) begin
                  voteCnt <= voteCnt + 2'h1;
               end
               if (rxRoll) begin
                  voteCnt <= 2'h0;
                  rxBits <= rxBits + 4'h1;
                  if (rxBits == 4'h0 && voteCnt[1]) begin
                     rxState <= RX_IDLE;
                  end else if (rxLast) begin
                     stopSeen <= voteCnt[1];
                     rxState <= RX_IDLE;
                  end else if (rxBits != 4'h0) begin
                     rxShift <= {voteCnt[1], rxShift[8:1]};
                  end
               end
            end
            default: rxState <= RX_IDLE;
         endcase
      end
   end
   // Delayed commit one cycle after final rollover
   logic commitPend;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         commitPend <= 1'b0;
      end else if (clkEn) begin
         commitPend <= rxState == RX_BITS && rxLast && !(rxBits == 4'h0);
      end
   end
   wire rxCommit = commitPend && (nine || stopOk) && rxAccept;
   // ****************************************
   // Software registers
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctl <= RST_BYTE;
         modeTop <= 1'b0;
         frameErr <= 1'b0;
         baud <= 21'h0;
         rxBuf <= RST_BYTE;
         slaveAddr <= RST_BYTE;
         slaveAddrMask <= RST_BYTE;
      end else if (clkEn) begin
         if (wrCtl) begin
            ctl <= wbDatIn[7:0];
            if (feSel) begin
               frameErr <= wbDatIn[CTL_TOP] & frameErr;
            end else begin
               modeTop <= wbDatIn[CTL_TOP];
            end
         end
         if (wrAddr) begin
            slaveAddr <= wbDatIn[7:0];
         end
         if (wrMask) begin
            slaveAddrMask <= wbDatIn[7:0];
         end
         if (wrBaud) begin
            baud <= wbDatIn[20:0];
         end
         if (commitPend && !stopOk) begin
            frameErr <= 1'b1;
         end
         if (txFinish) begin
            ctl[CTL_TXDONE] <= 1'b1;
         end
         if (rxCommit) begin
            rxBuf <= rxByte;
            ctl[CTL_RXNINTH] <= ninthIn;
            ctl[CTL_RXDONE] <= 1'b1;
         end
      end
   end
   // Bus answer and interrupt output
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wbAck <= 1'b0;
         wbDatOut <= 32'h0;
         serialIrq <= 1'b0;
      end else if (clkEn) begin
         wbAck <= busHit;
         wbDatOut <= busHit ? rdMux : 32'h0;
         serialIrq <= ctl[CTL_RXDONE] | ctl[CTL_TXDONE];
      end
   end
   // ****************************************
   // Checks
   // ****************************************
   sequence s_write;
      wrData;
   endsequence
   AST_TX_START_ON_ROLL: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(txBusy) |-> !txPin && $past(txReq)) else $error("start bit not at rollover");
   AST_TX_DONE: assert property (@(posedge clk_sys) disable iff (rst)
      txFinish && clkEn |=> ctl[CTL_TXDONE] && !txBusy) else $error("tx done not set");
   AST_TX_IDLE_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
      !txBusy |-> txPin) else $error("idle line low");
   AST_RX_GATE: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(rxState == RX_BITS) |-> $past(ctl[CTL_RXEN])) else $error("rx without enable");
   AST_RX_NOLOAD_FULL: assert property (@(posedge clk_sys) disable iff (rst)
      commitPend && ctl[CTL_RXDONE] && clkEn |=> $stable(rxBuf)) else $error("overwrite");
   AST_FE_STICKY: assert property (@(posedge clk_sys) disable iff (rst)
      frameErr && !wrCtl |=> frameErr) else $error("framing error self-cleared");
   AST_ACK_PULSE: assert property (@(posedge clk_sys) disable iff (rst)
      wbAck |=> !wbAck) else $error("ack held");
   AST_MATCH_RESET: assert property (@(posedge clk_sys) disable iff (rst)
      slaveAddr == 8'h00 && slaveAddrMask == 8'h00 |-> addrHit) else $error("no match");
endmodule : nbu_uart

// [core/nbu_pkg.sv]
// Package for the nine-bit UART with address match
package nbu_pkg;
   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_ADDR = 8'h08;
   localparam logic [7:0] OFS_MASK = 8'h0c;
   localparam logic [7:0] OFS_BAUD = 8'h10;
   // ****************************************
   // Control register fields
   // ****************************************
   localparam int CTL_RXDONE = 0;
   localparam int CTL_TXDONE = 1;
   localparam int CTL_RXNINTH = 2;
   localparam int CTL_TXNINTH = 3;
   localparam int CTL_RXEN = 4;
   localparam int CTL_MPEN = 5;
   localparam int CTL_MODE1 = 6;
   localparam int CTL_TOP = 7;
   // Baud register fields
   localparam int BD_RELOAD = 0;
   localparam int BD_BRT = 8;
   localparam int BD_DOUBLE = 16;
   localparam int BD_FESEL = 17;
   localparam int BD_SRCSEL = 18;
   localparam int BD_T1FAST = 19;
   localparam int BD_BRTFAST = 20;
   // ****************************************
   // Reset values and counts
   // ****************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] SAMPLE_A = 4'h7;
   localparam logic [3:0] SAMPLE_B = 4'h8;
   localparam logic [3:0] SAMPLE_C = 4'h9;
   localparam logic [3:0] FRAME9_BITS = 4'hb;
   localparam logic [3:0] FRAME8_BITS = 4'ha;
   localparam logic [3:0] SLOW_DIV = 4'hb;
   localparam logic [8:0] TIMER_TOP = 9'h100;
   // Mode-2 tick divisor: 16 ticks per bit at clock/32 or clock/64
   localparam logic [1:0] M2_DIV_FAST = 2'h1;
   localparam logic [1:0] M2_DIV_SLOW = 2'h3;
   // Bus request carrier
   typedef struct packed {
      logic [7:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
      logic we;
   } nbu_req_s;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_BITS = 2'b01
   } nbu_rx_e;
endpackage : nbu_pkg

// [tb/nbu_remote.sv]
// Remote serial node that sends frames and captures frames
`timescale 1ns/1ns
module nbu_remote (
   input wire logic clk_sys,
   input wire logic serIn,
   output logic serOut
);
   // ****************************************
   // Line driver and frame capture
   // ****************************************
   // Idle level between frames is high
   initial serOut = 1'b1;
   // Start, eight bits lsb first, ninth bit, stop
   task automatic send(input logic [7:0] b, input logic n9, input logic stop, input int per);
      logic [10:0] f;
      f = {stop, n9, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         serOut <= f[i];
         repeat (per) @(posedge clk_sys);
      end
      serOut <= 1'b1;
   endtask : send
   // Short low pulse that must not start a frame
   task automatic glitch(input int len);
      serOut <= 1'b0;
      repeat (len) @(posedge clk_sys);
      serOut <= 1'b1;
   endtask : glitch
   // Measure start bit length, then sample mid-bit
   task automatic capture(input int per, output logic [10:0] f, output int len);
      len = 0;
      f = 11'h0;
      while (serIn !== 1'b0) @(posedge clk_sys);
      while (serIn === 1'b0) begin
         @(posedge clk_sys);
         len++;
      end
      repeat (per / 2) @(posedge clk_sys);
      f[1] = serIn;
      for (int i = 2; i < 11; i++) begin
         repeat (per) @(posedge clk_sys);
         f[i] = serIn;
      end
   endtask : capture
endmodule : nbu_remote

// [tb/test_nbu_uart.sv]
// Self-checking bench for the nine-bit UART
`timescale 1ns/1ns
module test_nbu_uart;
   import nbu_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic wbCyc = 1'b0, wbStb = 1'b0;
   nbu_req_s req = '0;
   logic [31:0] wbDatOut;
   logic wbAck, rxPin, txPin, serialIrq;
   int n_mismatch = 0, n_tests = 0, cyc = 0;
   int perTab[5] = '{64, 32, 16, 64, 192};
   logic [31:0] bdTab[5] = '{32'h0, 32'h10000, 32'h900ff, 32'h14fe00, 32'h100ff};
   logic [31:0] ctl;
   logic [7:0] adTab[3] = '{8'hc2, 8'hc1, 8'hff};
   nbu_uart nbu_uart_i (.clk_sys(clk_sys), .rst(rst), .clkEn(1'b1), .wbCyc(wbCyc),
      .wbStb(wbStb), .wbWe(req.we), .wbAdr(req.adr), .wbDatIn(req.dat), .wbSel(req.sel),
      .wbDatOut(wbDatOut), .wbAck(wbAck), .rxPin(rxPin), .txPin(txPin),
      .serialIrq(serialIrq));
   nbu_remote nbu_remote_i (.clk_sys(clk_sys), .serIn(txPin), .serOut(rxPin));
   // ****************************************
   // Clock, hang limit and bus tasks
   // ****************************************
   always #5 clk_sys = ~clk_sys;
   // Hang limit counted in clock cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (n_mismatch == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Classic single cycle, held until ack is sampled
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      req <= '{adr: a, dat: d, sel: s, we: w};
      do begin
         @(posedge clk_sys);
         n++;
      end while (wbAck !== 1'b1);
      q = wbDatOut;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, 4'hf, q);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, 4'hf, q);
      chk(q & m, e);
   endtask : rd_chk
   // Poll control until a flag is seen, bounded
   task automatic wflag(input int b);
      logic [31:0] q;
      for (int k = 0; k < 200; k++) begin
         bus(OFS_CONTROL, 1'b0, 32'h0, 4'hf, q);
         if (q[b] === 1'b1) break;
      end
   endtask : wflag
   // One received frame and its visible outcome
   task automatic rx_one(input logic [7:0] b, input logic n9, input logic stop,
      input logic done, input int per);
      nbu_remote_i.send(b, n9, stop, per);
      repeat (16) @(posedge clk_sys);
      rd_chk(OFS_CONTROL, 32'h1, {31'h0, done});
      if (done) begin
         rd_chk(OFS_DATA, 32'hff, {24'h0, b});
         rd_chk(OFS_CONTROL, 32'h4, {29'h0, n9, 2'h0});
      end
   endtask : rx_one
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [31:0] q;
      logic [10:0] frm;
      int len;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      chk({31'h0, txPin}, 32'h1);
      rd_chk(OFS_CONTROL, 32'hff, 32'h0);
      rd_chk(OFS_ADDR, 32'hff, 32'h0);
      rd_chk(OFS_MASK, 32'hff, 32'h0);
      rd_chk(8'h14, 32'hffffffff, 32'h0);
      bus(OFS_ADDR, 1'b1, 32'h55, 4'he, q);
      rd_chk(OFS_ADDR, 32'hff, 32'h0);
      // Transmit at every rate source
      for (int i = 0; i < 5; i++) begin
         ctl = (i < 2 ? 32'h80 : 32'hc0) | (i[0] ? 32'h8 : 32'h0);
         wr(OFS_BAUD, bdTab[i]);
         wr(OFS_CONTROL, ctl);
         fork
            wr(OFS_DATA, 32'ha5);
            nbu_remote_i.capture(perTab[i], frm, len);
         join
         chk(32'(len), 32'(perTab[i]));
         chk(32'(frm), {21'h0, 1'b1, i[0], 8'ha5, 1'b0});
         wflag(CTL_TXDONE);
         rd_chk(OFS_CONTROL, 32'h2, 32'h2);
         chk({31'h0, serialIrq}, 32'h1);
      end
      wr(OFS_CONTROL, 32'h80);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, serialIrq}, 32'h0);
      // Receive in mode 2, discard while flag set, false start
      ctl = 32'h90;
      wr(OFS_BAUD, 32'h10000);
      wr(OFS_CONTROL, ctl);
      rx_one(8'h3c, 1'b0, 1'b1, 1'b1, 32);
      chk({31'h0, serialIrq}, 32'h1);
      nbu_remote_i.send(8'h5a, 1'b1, 1'b1, 32);
      rd_chk(OFS_DATA, 32'hff, 32'h3c);
      rd_chk(OFS_CONTROL, 32'h4, 32'h0);
      wr(OFS_CONTROL, ctl);
      nbu_remote_i.glitch(4);
      repeat (64) @(posedge clk_sys);
      rd_chk(OFS_CONTROL, 32'h1, 32'h0);
      rx_one(8'hc3, 1'b1, 1'b1, 1'b1, 32);
      // Missing stop bit and sticky framing error
      wr(OFS_CONTROL, ctl);
      wr(OFS_BAUD, 32'h30000);
      rx_one(8'h77, 1'b1, 1'b0, 1'b1, 32);
      rd_chk(OFS_CONTROL, 32'h80, 32'h80);
      wr(OFS_CONTROL, ctl);
      rx_one(8'h11, 1'b0, 1'b1, 1'b1, 32);
      rd_chk(OFS_CONTROL, 32'h80, 32'h80);
      wr(OFS_CONTROL, 32'h10);
      rd_chk(OFS_CONTROL, 32'h80, 32'h0);
      wr(OFS_BAUD, 32'h10000);
      rd_chk(OFS_CONTROL, 32'h80, 32'h80);
      // Multiprocessor gating and address match
      ctl = 32'hb0;
      wr(OFS_CONTROL, ctl);
      rx_one(8'h12, 1'b1, 1'b1, 1'b1, 32);
      wr(OFS_CONTROL, ctl);
      rx_one(8'h12, 1'b0, 1'b1, 1'b0, 32);
      wr(OFS_ADDR, 32'hc0);
      wr(OFS_MASK, 32'hfd);
      for (int i = 0; i < 3; i++) begin
         rx_one(adTab[i], 1'b1, 1'b1, i != 1, 32);
         wr(OFS_CONTROL, ctl);
      end
      // Mode 1 with stop check, then receive disabled
      ctl = 32'h70;
      wr(OFS_BAUD, 32'h900ff);
      wr(OFS_CONTROL, ctl);
      rx_one(8'hc2, 1'b0, 1'b1, 1'b0, 16);
      rx_one(8'hc2, 1'b1, 1'b1, 1'b1, 16);
      wr(OFS_CONTROL, ctl);
      rx_one(8'hc1, 1'b1, 1'b1, 1'b0, 16);
      wr(OFS_CONTROL, 32'h60);
      rx_one(8'hc2, 1'b1, 1'b1, 1'b0, 16);
      report_and_stop();
   end
endmodule : test_nbu_uart
